// File: test/ldc_duty_current_chk.sv
// checker on the duty and current block ports
`timescale 1ns/1ps
module ldc_duty_current_chk
  import ldc_pkg::*;
(
  input wire logic       clock, rst, reg_wr, reg_rd, reg_hit, addr_inc_allow,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, drive_current_code_out1,
  input wire ldc_pkg::ldc_mode_t out_mode,
  input wire logic [4:0] pwm_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_hit_decode: assert property (
    reg_hit == (reg_addr inside {[8'h1a:8'h1e], 8'h26})) else $error("hit decode");
  a_no_autoinc: assert property (
    addr_inc_allow == !(reg_addr inside {[8'h16:8'h1e]})) else $error("inc allow");
  a_curr_write: assert property (reg_wr && reg_addr == 8'h26 |=>
    drive_current_code_out1 == $past(reg_wdata)) else $error("current write");
  a_curr_hold: assert property (!(reg_wr && reg_addr == 8'h26) |=>
    $stable(drive_current_code_out1)) else $error("current hold");
  a_engine_off: assert property (out_mode == ldc_mode_engine |=>
    pwm_out == 5'h00) else $error("engine gating");
  a_rd_unmapped: assert property (reg_rd && !reg_hit |=>
    reg_rdata == 8'h00) else $error("unmapped read");
  a_rd_hold: assert property (!reg_rd |=>
    $stable(reg_rdata)) else $error("read data hold");
  a_rd_current: assert property (reg_rd && reg_addr == 8'h26 |=>
    reg_rdata == $past(drive_current_code_out1)) else $error("current read");
endmodule : ldc_duty_current_chk
////////////////////////////////////////
bind ldc_duty_current ldc_duty_current_chk ldc_duty_current_chk_i (.*);

// File: test/ldc_host.sv
// host model for the strobe register bus
`timescale 1ns/1ps
module ldc_host (
  // bus
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr, reg_wdata,
  output logic            reg_wr, reg_rd
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
  // one transfer per register, no auto increment assumed
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clock);
    #1 reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clock);
    #1 reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
endmodule : ldc_host

// File: test/test_led_duty_and_current_regs.sv
// bench: reset values, readback, pwm counts and mode gating
`timescale 1ns/1ps
module test_led_duty_and_current_regs;
  import ldc_pkg::*;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  ldc_mode_t  out_mode = ldc_mode_direct;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, drive_current_code_out1, got;
  logic       reg_wr, reg_rd, reg_hit, addr_inc_allow;
  logic [4:0] pwm_out;
  int         fails = 0, n_checks = 0, cycles = 0, cnt[5];
  logic [7:0] duty[5] = '{8'h00, 8'h01, 8'hff, 8'h80, 8'h02};
  always #25 clock = ~clock;
  ldc_duty_current ldc_duty_current_i (.*);
  ldc_host ldc_host_i (.*);
  task automatic chk(input string what, input logic [7:0] exp, seen);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, exp);
    ldc_host_i.rd(a, got);
    chk("register read", exp, got);
  endtask : rdchk
  task automatic results();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  // tests need about 560 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      results();
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    #1 rst = 1'b0;
    for (int i = 0; i < 5; i++) rdchk(ldc_off_out5_duty + 8'(i), ldc_rst_duty);
    rdchk(ldc_off_out1_curr, ldc_rst_curr);
    rdchk(ldc_noinc_lo, 8'h00);
    chk("address step allow", 8'h00, {7'h0, addr_inc_allow});
    chk("register hit", 8'h00, {7'h0, reg_hit});
    $display("reset test done");
    for (int i = 0; i < 5; i++) ldc_host_i.wr(ldc_off_out5_duty + 8'(i), duty[i]);
    ldc_host_i.wr(ldc_off_out1_curr, 8'hff);
    for (int i = 0; i < 5; i++) rdchk(ldc_off_out5_duty + 8'(i), duty[i]);
    rdchk(ldc_off_out1_curr, 8'hff);
    chk("register hit", 8'h01, {7'h0, reg_hit});
    chk("address step allow", 8'h01, {7'h0, addr_inc_allow});
    chk("current port", 8'hff, drive_current_code_out1);
    $display("register test done");
    repeat (255) @(posedge clock);
    repeat (255) begin
      @(posedge clock);
      #1;
      for (int i = 0; i < 5; i++) cnt[i] += pwm_out[i];
    end
    for (int i = 0; i < 5; i++) chk("pwm high count", duty[i], 8'(cnt[i]));
    $display("pwm test done");
    @(posedge clock);
    #1 out_mode = ldc_mode_engine;
    repeat (2) @(posedge clock);
    #1;
    chk("engine gating", 8'h00, {3'h0, pwm_out});
    $display("mode test done");
    results();
  end
endmodule : test_led_duty_and_current_regs

// File: verilog/ldc_duty_current.sv
// duty-cycle registers for outputs 5..9, drive current for output 1, and pwm generation
//
// Overview of operation
// (RQ1) Each of outputs 5 to 9 has its own 8-bit duty code that shapes only its own pwm.
// (RQ2) A duty code of zero keeps the output off for the whole period.
// (RQ3) Duty grows in steps of 1/255 of the period and code ff keeps the output on throughout.
// (RQ4) All five duty codes reset to zero and can be read and written by the host.
// (RQ5) Each current source has an 8-bit current code in 100 uA steps up to 25.5 mA.
// (RQ6) The output 1 current code resets to af (17.5 mA) and is readable and writable.
// (RQ7) Duty codes act only in direct control mode, which is the mode after reset.
// (RQ8) Register addresses 16 to 1e do not auto increment; the host addresses each one alone.
// (RQ9) Pwm comes from a free-running 255-count counter; an output is on while count < code.
`timescale 1ns/1ps
module ldc_duty_current
  import ldc_pkg::*;
(
  // clock and reset
  input  wire logic                            clock,
  input  wire logic                            rst,
  // register access from the serial bus front end
  input  wire logic [ldc_pkg::ldc_addr_w-1:0]  reg_addr,
  input  wire logic [ldc_pkg::ldc_data_w-1:0]  reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [ldc_pkg::ldc_data_w-1:0]  reg_rdata,
  output logic                                 reg_hit,
  output logic                                 addr_inc_allow,
  // mode select from the output control logic
  input  wire ldc_pkg::ldc_mode_t              out_mode,
  // outputs
  output logic      [ldc_pkg::ldc_duty_outs-1:0] pwm_out,
  output logic      [ldc_pkg::ldc_data_w-1:0]  drive_current_code_out1
);
  import ldc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  // inclusive window test shared by the register decode and the no-increment range
  function automatic logic in_window(
    input logic [7:0] a,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    in_window = (a >= lo) && (a <= hi);
  endfunction : in_window

  // index 0..4 for outputs 5..9, or 3'h7 when the address is not a duty register
  function automatic logic [2:0] duty_index(input logic [7:0] a);
    logic [7:0] offset;
    offset = a - ldc_off_out5_duty;
    if (in_window(a, ldc_off_out5_duty, ldc_off_out9_duty)) begin
      duty_index = offset[2:0];
    end else begin
      duty_index = 3'h7;
    end
  endfunction : duty_index

  logic [2:0] wr_idx;
  logic       duty_hit;
  logic       curr_hit;

  assign wr_idx   = duty_index(reg_addr);
  assign duty_hit = (wr_idx != 3'h7);
  assign curr_hit = (reg_addr == ldc_off_out1_curr);
  assign reg_hit  = duty_hit || curr_hit;
  // the front end must not step the address inside this window
  assign addr_inc_allow = !in_window(reg_addr, ldc_noinc_lo, ldc_noinc_hi); // [RQ8]

  ////////////////////////////////////////////////////////////////////////////
  // write enables

  logic [ldc_duty_outs-1:0] duty_we;
  logic                     curr_we;

  // one enable per duty code so a write can never reach a neighbouring output
  always_comb begin
    for (int i = 0; i < ldc_duty_outs; i++) begin
      duty_we[i] = reg_wr && (wr_idx == 3'(i)); // [RQ1]
    end
  end

  // writes to unmapped addresses are dropped; reg_hit low is the only sign of it
  assign curr_we = reg_wr && curr_hit;

  ////////////////////////////////////////////////////////////////////////////
  // duty codes

  logic [7:0] duty_reg  [ldc_duty_outs];
  logic [7:0] duty_next [ldc_duty_outs];

  // a new code lands at the strobe edge and acts from the next compare, even mid-period
  always_comb begin
    for (int i = 0; i < ldc_duty_outs; i++) begin
      if (duty_we[i]) begin
        duty_next[i] = reg_wdata; // [RQ1] [RQ4]
      end else begin
        duty_next[i] = duty_reg[i];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < ldc_duty_outs; i++) begin
        duty_reg[i] <= ldc_rst_duty; // [RQ4]
      end
    end else begin
      for (int i = 0; i < ldc_duty_outs; i++) begin
        duty_reg[i] <= duty_next[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive current code of output 1

  logic [7:0] curr_reg;
  logic [7:0] curr_next;

  // every code is legal, so the value goes to the current source unchecked
  always_comb begin
    if (curr_we) begin
      curr_next = reg_wdata; // [RQ5] [RQ6]
    end else begin
      curr_next = curr_reg;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      curr_reg <= ldc_rst_curr; // [RQ6]
    end else begin
      curr_reg <= curr_next;
    end
  end

  assign drive_current_code_out1 = curr_reg; // [RQ5]

  ////////////////////////////////////////////////////////////////////////////
  // read data

  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // a read in the same cycle as a write returns the old value; unmapped reads give zero
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      if (duty_hit) begin
        rdata_next = duty_reg[wr_idx]; // [RQ4]
      end else if (curr_hit) begin
        rdata_next = curr_reg; // [RQ6]
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // read data stands until the next read strobe
  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // pwm period counter

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       cnt_wrap;

  // 255 states so one code step is exactly 1/255 of the period
  assign cnt_wrap = (cnt_reg == ldc_pwm_last);

  // the counter never stops, so all outputs keep one common phase across duty writes
  always_comb begin
    if (cnt_wrap) begin
      cnt_next = 8'h00; // [RQ9] [RQ3]
    end else begin
      cnt_next = cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm outputs

  logic                     direct_en;
  logic [ldc_duty_outs-1:0] out_en;
  // engine-driven pwm lives elsewhere; here the output is simply held off
  assign direct_en = (out_mode == ldc_mode_direct); // [RQ7]

  // one enable per output; all follow the shared mode, so every gate is the same
  always_comb begin
    for (int i = 0; i < ldc_duty_outs; i++) begin
      out_en[i] = direct_en; // [RQ7]
    end
  end

  // pwm_out trails the counter by one clock on every output alike
  for (genvar g = 0; g < ldc_duty_outs; g++) begin : g_ch
    ldc_pwm_channel u_ch (
      .clock   (clock),
      .rst     (rst),
      .count   (cnt_reg),
      .duty    (duty_reg[g]),
      .enable  (out_en[g]),
      .pwm_out (pwm_out[g])
    ); // [RQ1]
  end
endmodule : ldc_duty_current

// File: verilog/ldc_pkg.sv
// package: register map, reset values and pwm timing for the duty and current block
package ldc_pkg;
  localparam int unsigned ldc_data_w = 8;
  localparam int unsigned ldc_addr_w = 8;
  localparam int unsigned ldc_duty_outs = 5;

  // register offsets
  localparam logic [7:0] ldc_off_out5_duty = 8'h1a;
  localparam logic [7:0] ldc_off_out6_duty = 8'h1b;
  localparam logic [7:0] ldc_off_out7_duty = 8'h1c;
  localparam logic [7:0] ldc_off_out8_duty = 8'h1d;
  localparam logic [7:0] ldc_off_out9_duty = 8'h1e;
  localparam logic [7:0] ldc_off_out1_curr = 8'h26;
  // range with no address auto increment
  localparam logic [7:0] ldc_noinc_lo      = 8'h16;
  localparam logic [7:0] ldc_noinc_hi      = 8'h1e;

  // reset values
  localparam logic [7:0] ldc_rst_duty      = 8'h00;
  localparam logic [7:0] ldc_rst_curr      = 8'haf;

  // pwm period: 255 counts, counter runs 0..254
  localparam logic [7:0] ldc_pwm_last      = 8'hfe;
  localparam logic [7:0] ldc_duty_full     = 8'hff;

  typedef enum logic {
    ldc_mode_direct,
    ldc_mode_engine
  } ldc_mode_t;
endpackage : ldc_pkg

// File: verilog/ldc_pwm_channel.sv
// one pwm output comparing a shared period counter with a duty code
`timescale 1ns/1ps
module ldc_pwm_channel
  import ldc_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // pwm inputs
  input  wire logic [7:0] count,
  input  wire logic [7:0] duty,
  input  wire logic       enable,
  // output
  output logic            pwm_out
);
  logic pwm_reg;
  logic pwm_next;

  always_comb begin
    // full code forces constant on so no glitch appears at wrap
    if (!enable) begin
      pwm_next = 1'b0;
    end else if (duty == ldc_duty_full) begin
      pwm_next = 1'b1; // [RQ3]
    end else begin
      pwm_next = (count < duty); // [RQ2] [RQ9]
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwm_reg <= 1'b0;
    end else begin
      pwm_reg <= pwm_next;
    end
  end

  assign pwm_out = pwm_reg;
endmodule : ldc_pwm_channel
